// ---- core/spi_master_pkg.sv ----
// Shared constants, register map and carrier types for the SPI master datapath
package spi_master_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] OFF_CONTROL    = 3'h0;
  localparam logic [2:0] OFF_STATUS     = 3'h1;
  localparam logic [2:0] OFF_TX_HOLD    = 3'h2;
  localparam logic [2:0] OFF_RX_HOLD    = 3'h3;
  localparam logic [2:0] OFF_SLAVE_SEL  = 3'h4;
  localparam logic [2:0] OFF_IRQ_STATUS = 3'h5;
  localparam logic [2:0] OFF_IRQ_MASK   = 3'h6;

  // Status register bit positions
  localparam int STAT_TX_EMPTY = 0;
  localparam int STAT_RX_FULL  = 1;
  localparam int STAT_BUSY     = 2;
  localparam int STAT_ERROR    = 3;

  // Interrupt status and mask bit positions
  localparam int IRQ_TX  = 0;
  localparam int IRQ_RX  = 1;
  localparam int IRQ_ERR = 2;
  localparam int IRQ_W   = 3;

  // Reset values
  localparam logic [7:0]       CONTROL_RESET   = 8'h00;
  localparam logic [7:0]       SLAVE_SEL_RESET = 8'h00;
  localparam logic [7:0]       DATA_RESET      = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET       = 3'h0;

  // Byte framing: last bit index of a byte
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Half period of the internal serial clock at divider setting 0, in system clocks
  localparam logic [4:0] HALF_BASE = 5'h02;

  typedef struct packed {
    logic       reserved;
    logic       miso_sample_edge_select;
    logic [1:0] sck_divider_select;
    logic       cpol;
    logic       cpha;
    logic       start;
    logic       enable;
  } control_t;

  typedef struct packed {
    logic [1:0] sck_divider_select;
    logic       cpol;
    logic       cpha;
  } sck_cfg_t;

  typedef struct packed {
    logic phase0_clock_gate;
    logic phase1_clock_gate;
  } sck_gate_t;

  typedef struct packed {
    logic sck_int_re;
    logic sck_int_fe;
    logic sck_ext_re;
    logic sck_ext_fe;
    logic sck_out;
  } sck_status_t;

  typedef enum {
    ST_IDLE, ST_ASSERT_SS1, ST_ASSERT_SS2, ST_UNMASK, ST_XFER, ST_DONE,
    ST_CHK_START, ST_MASK, ST_HOLD1, ST_HOLD2, ST_NEGATE
  } ctl_state_t;

endpackage

// ---- core/sck_clock_gen.sv ----
// Serial clock divider, phase gating and output clock register
`timescale 1ns/10ps
`default_nettype none
module sck_clock_gen (
  input  wire logic                        clk,     // System clock
  input  wire logic                        sys_rst, // Synchronous reset, high
  input  wire spi_master_pkg::sck_cfg_t    cfg,     // Divider, polarity, phase
  input  wire spi_master_pkg::sck_gate_t   gate,    // Phase clock gates
  output var  spi_master_pkg::sck_status_t stat     // Edge pulses and serial clock
);
  import spi_master_pkg::*;

  logic [4:0] cnt;
  logic [4:0] half;
  logic       tick;
  logic       sck_int;
  logic       sck_out;
  logic       sck_out_d;
  logic       pre;

  // The internal clock runs free so the control sequencer always has edges
  assign half = HALF_BASE << cfg.sck_divider_select;
  assign tick = (cnt == (half - 5'h01));

  always_ff @(posedge clk) begin
    if (sys_rst || tick) begin
      cnt <= 5'h00;
    end else begin
      cnt <= cnt + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sck_int <= 1'b0;
    end else if (tick) begin
      sck_int <= ~sck_int;
    end
  end

  // Phase 1 clock follows the internal clock, phase 0 is its inverse
  always_comb begin
    if (cfg.cpha) begin
      pre = gate.phase1_clock_gate & sck_int;
    end else begin
      pre = gate.phase0_clock_gate & ~sck_int;
    end
  end

  // Registered output lags the internal clock by one system clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sck_out   <= 1'b0;
      sck_out_d <= 1'b0;
    end else begin
      sck_out   <= pre ^ cfg.cpol;
      sck_out_d <= sck_out;
    end
  end

  always_comb begin
    stat.sck_int_re = tick & ~sck_int;
    stat.sck_int_fe = tick & sck_int;
    stat.sck_ext_re = sck_out & ~sck_out_d;
    stat.sck_ext_fe = ~sck_out & sck_out_d;
    stat.sck_out    = sck_out;
  end

endmodule
`default_nettype wire

// ---- core/spi_master_datapath.sv ----
// SPI master datapath: registers, control sequencer, shift registers and flags
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// R1 - Transmit-empty flag sets when holding data loads into the transmit shifter.
// R2 - Transmit-empty flag clears on a holding register write, and on reset.
// R3 - Receive-full flag sets on holding load, clears when software reads it.
// R4 - A free-running internal serial clock divides the system clock per divider setting.
// R5 - Output clock built from gated phase clocks, idle at polarity level.
// R6 - Eight-bit transmit shifter loads on strobe, shifts on internal rising edges.
// R7 - MOSI passes one system-clock register to stay aligned with output clock.
// R8 - Separate receive shifter shifts on each rising external clock edge.
// R9 - MISO sampled on both edges; select bit 1 rising, 0 falling.
// R10 - Software sets select bit 1 when phase equals polarity, else 0.
// R11 - Receive bits counted; full byte copies into the receive holding register.
// R12 - Bus conflict raises an interrupt request when its mask enables it.
// R13 - Software polls the error bit or services the interrupt until cleared.
// R14 - A transfer starts only with start set and transmit-empty clear.
// R15 - Master-select input forces idle and releases MOSI, select and clock.
// R16 - Both shifters move most significant bit first.
module spi_master_datapath (
  input  wire logic       clk,             // System clock, 100 MHz
  input  wire logic       sys_rst,         // Synchronous reset, high
  input  wire logic [2:0] addr,            // Register index
  input  wire logic [7:0] wdata,           // Write data
  input  wire logic       wr,              // Write strobe
  input  wire logic       rd,              // Read strobe
  output logic      [7:0] rdata,           // Read data, cycle after rd
  output logic            irq,             // Interrupt request level
  output logic            mosi,            // Serial data out
  output logic            mosi_oe_n,       // MOSI drive enable, low drives
  input  wire logic       miso,            // Serial data in
  output logic            sck,             // Serial clock out
  output logic            sck_oe_n,        // Clock drive enable, low drives
  output logic      [7:0] ss_n,            // Slave selects, low selects
  output logic            ss_oe_n,         // Select drive enable, low drives
  input  wire logic       master_select_n  // Another master claims the bus, low
);
  import spi_master_pkg::*;

  control_t            control_register;
  logic [7:0]          slave_sel;
  logic [7:0]          tx_holding_register;
  logic [7:0]          rx_holding_register;
  logic [7:0]          tx_shift;
  logic [2:0]          tx_bits;
  logic [7:0]          rx_shift;
  logic [2:0]          rx_bits;
  logic                fall_sample;
  logic                rx_in;
  logic                tx_empty;
  logic                rx_full;
  logic                bus_conflict_error;
  logic [IRQ_W-1:0]    irq_status;
  logic [IRQ_W-1:0]    irq_mask;
  logic [IRQ_W-1:0]    irq_event;
  ctl_state_t          state;
  ctl_state_t          next_state;
  logic                ss_active;
  logic                tx_load;
  logic                tx_shift_en;
  logic                rx_load;
  logic                conflict;
  logic                start_ok;
  logic                trail_edge;
  logic                wr_control;
  logic                wr_tx;
  logic                wr_status;
  logic                rd_rx;
  logic                rd_irq;
  sck_cfg_t            sck_cfg;
  sck_gate_t           sck_gate;
  sck_status_t         sck_stat;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
    return a == off;
  endfunction

  assign wr_control = wr & hit(addr, OFF_CONTROL);
  assign wr_status  = wr & hit(addr, OFF_STATUS);
  assign wr_tx      = wr & hit(addr, OFF_TX_HOLD);
  assign rd_rx      = rd & hit(addr, OFF_RX_HOLD);
  assign rd_irq     = rd & hit(addr, OFF_IRQ_STATUS);

  assign conflict = ~master_select_n;
  assign start_ok = control_register.start & ~tx_empty; // R14

  // Software-visible registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      control_register <= control_t'(CONTROL_RESET);
    end else if (wr_control) begin
      control_register          <= control_t'(wdata);
      control_register.reserved <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slave_sel <= SLAVE_SEL_RESET;
    end else if (wr && hit(addr, OFF_SLAVE_SEL)) begin
      slave_sel <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_holding_register <= DATA_RESET;
    end else if (wr_tx) begin
      tx_holding_register <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_mask <= IRQ_RESET;
    end else if (wr && hit(addr, OFF_IRQ_MASK)) begin
      irq_mask <= wdata[IRQ_W-1:0];
    end
  end

  // Serial clock generation
  assign sck_cfg.sck_divider_select = control_register.sck_divider_select;
  assign sck_cfg.cpol               = control_register.cpol;
  assign sck_cfg.cpha               = control_register.cpha;

  sck_clock_gen u_sck (
    .clk     (clk),
    .sys_rst (sys_rst),
    .cfg     (sck_cfg),
    .gate    (sck_gate),
    .stat    (sck_stat)
  ); // R4

  // Control sequencer, paced by the internal serial clock
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_ok) begin
          next_state = ST_ASSERT_SS1; // R14
        end
      end
      ST_ASSERT_SS1: begin
        if (sck_stat.sck_int_re) begin
          next_state = ST_ASSERT_SS2;
        end
      end
      ST_ASSERT_SS2: begin
        if (sck_stat.sck_int_fe) begin
          next_state = ST_UNMASK;
        end
      end
      ST_UNMASK: begin
        if (sck_stat.sck_int_re) begin
          next_state = ST_XFER;
        end
      end
      ST_XFER: begin
        if (sck_stat.sck_int_re && tx_bits == LAST_BIT) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (sck_stat.sck_int_fe) begin
          next_state = ST_CHK_START;
        end
      end
      ST_CHK_START: begin
        if (start_ok && control_register.cpha) begin
          next_state = ST_UNMASK; // R14
        end else if (trail_edge) begin
          next_state = ST_MASK;
        end
      end
      ST_MASK: begin
        if (sck_stat.sck_int_fe) begin
          next_state = ST_HOLD1;
        end
      end
      ST_HOLD1: begin
        if (sck_stat.sck_int_fe) begin
          next_state = ST_HOLD2;
        end
      end
      ST_HOLD2: begin
        if (sck_stat.sck_int_fe) begin
          next_state = ST_NEGATE;
        end
      end
      ST_NEGATE: begin
        if (sck_stat.sck_int_fe) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (conflict || !control_register.enable) begin
      next_state = ST_IDLE; // R15
    end
  end

  // Clock is masked only once the pin has settled back at its idle level
  assign trail_edge = (sck_stat.sck_out == control_register.cpol);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    // Gates close with the eighth pulse; left open past the byte they emit a ninth edge
    sck_gate.phase1_clock_gate = (state == ST_UNMASK) || (state == ST_XFER); // R5
    sck_gate.phase0_clock_gate = (state == ST_XFER); // R5
    ss_active = (state != ST_IDLE) && (state != ST_NEGATE);
  end

  // Transmit path
  assign tx_load     = (state == ST_UNMASK) && sck_stat.sck_int_re && !conflict;
  assign tx_shift_en = (state == ST_XFER) && sck_stat.sck_int_re && (tx_bits != LAST_BIT);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_shift <= DATA_RESET;
      tx_bits  <= 3'h0;
    end else if (tx_load) begin
      tx_shift <= tx_holding_register; // R6
      tx_bits  <= 3'h0;
    end else if (tx_shift_en) begin
      tx_shift <= {tx_shift[6:0], 1'b0}; // R6 R16
      tx_bits  <= tx_bits + 3'h1;
    end
  end

  // Set wins over a write in the same cycle so no load is missed
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_empty <= 1'b0; // R2
    end else if (tx_load) begin
      tx_empty <= 1'b1; // R1
    end else if (wr_tx) begin
      tx_empty <= 1'b0; // R2
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mosi <= 1'b0;
    end else begin
      mosi <= tx_shift[7]; // R7
    end
  end

  // Receive path; a rising-edge select takes MISO one system clock after that edge
  assign rx_in = control_register.miso_sample_edge_select ? miso : fall_sample; // R9

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fall_sample <= 1'b0;
    end else if (sck_stat.sck_ext_fe) begin
      fall_sample <= miso; // R9
    end
  end

  assign rx_load = sck_stat.sck_ext_re && (rx_bits == LAST_BIT);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_shift <= DATA_RESET;
    end else if (sck_stat.sck_ext_re) begin
      rx_shift <= {rx_shift[6:0], rx_in}; // R8 R16
    end
  end

  // Counter restarts in idle so an aborted byte cannot skew the next one
  always_ff @(posedge clk) begin
    if (sys_rst || state == ST_IDLE) begin
      rx_bits <= 3'h0;
    end else if (sck_stat.sck_ext_re) begin
      rx_bits <= rx_bits + 3'h1; // R11
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_holding_register <= DATA_RESET;
    end else if (rx_load) begin
      rx_holding_register <= {rx_shift[6:0], rx_in}; // R11
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_full <= 1'b0;
    end else if (rx_load) begin
      rx_full <= 1'b1; // R3
    end else if (rd_rx) begin
      rx_full <= 1'b0; // R3
    end
  end

  // Bus conflict and interrupts
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_conflict_error <= 1'b0;
    end else if (conflict) begin
      bus_conflict_error <= 1'b1;
    end else if (wr_status && wdata[STAT_ERROR]) begin
      bus_conflict_error <= 1'b0;
    end
  end

  always_comb begin
    irq_event          = '0;
    irq_event[IRQ_TX]  = tx_load;
    irq_event[IRQ_RX]  = rx_load;
    irq_event[IRQ_ERR] = conflict; // R12
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_status <= IRQ_RESET;
    end else if (rd_irq) begin
      irq_status <= irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  assign irq = |(irq_status & irq_mask); // R12

  // Pins; drivers release one clock after a competing master appears
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mosi_oe_n <= 1'b1;
      sck_oe_n  <= 1'b1;
      ss_oe_n   <= 1'b1;
    end else begin
      mosi_oe_n <= conflict; // R15
      sck_oe_n  <= conflict; // R15
      ss_oe_n   <= conflict; // R15
    end
  end

  assign sck = sck_stat.sck_out;

  for (genvar i = 0; i < 8; i++) begin : g_ss
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        ss_n[i] <= 1'b1;
      end else begin
        ss_n[i] <= ~(ss_active & slave_sel[i]);
      end
    end
  end

  // Read port; data stands for exactly one cycle
  always_ff @(posedge clk) begin
    if (sys_rst || !rd) begin
      rdata <= DATA_RESET;
    end else begin
      case (addr)
        OFF_CONTROL:    rdata <= control_register;
        OFF_STATUS:     rdata <= {4'h0, bus_conflict_error, state != ST_IDLE, rx_full, tx_empty};
        OFF_TX_HOLD:    rdata <= tx_holding_register;
        OFF_RX_HOLD:    rdata <= rx_holding_register;
        OFF_SLAVE_SEL:  rdata <= slave_sel;
        OFF_IRQ_STATUS: rdata <= {5'h00, irq_status};
        OFF_IRQ_MASK:   rdata <= {5'h00, irq_mask};
        default:        rdata <= DATA_RESET;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [7:0] tx_hold_at_load;
  always_ff @(posedge clk) begin
    if (tx_load) begin
      tx_hold_at_load <= tx_holding_register;
    end
  end

  AST_TX_EMPTY_SET: assert property (tx_load |=> tx_empty && irq_status[IRQ_TX]) // R1
    else $error("transmit empty not set by load");
  AST_TX_EMPTY_CLR: assert property (wr_tx && !tx_load |=> !tx_empty) // R2
    else $error("transmit empty not cleared by write");
  AST_RX_FULL_SET: assert property (rx_load |=> rx_full && rx_holding_register[0] == $past(rx_in)) // R3
    else $error("receive full or data wrong after load");
  AST_RX_FULL_CLR: assert property (rd_rx && !rx_load |=> !rx_full) // R3
    else $error("receive full not cleared by read");
  AST_START_GUARD: assert property ((state == ST_IDLE) ##1 (state == ST_ASSERT_SS1) |-> $past(start_ok)) // R14
    else $error("transfer started without start and data");
  AST_CONFLICT: assert property (conflict |=> state == ST_IDLE && mosi_oe_n && sck_oe_n && ss_oe_n) // R15
    else $error("outputs not released on bus conflict");
  AST_CONFLICT_IRQ: assert property (conflict && irq_mask[IRQ_ERR] && !wr |=> // R12
                                     irq && bus_conflict_error)
    else $error("bus conflict raised no interrupt");
  AST_MSB_FIRST: assert property (tx_load |=> ##1 mosi == tx_hold_at_load[7]) // R16 R7
    else $error("first bit on MOSI is not bit 7");
  AST_SCK_IDLE: assert property ((state == ST_IDLE)[*2] |-> sck == control_register.cpol ||
                                  $changed(control_register.cpol)) // R5
    else $error("serial clock not at idle level");
  AST_DIVIDER: assert property (sck_stat.sck_int_re |=> !sck_stat.sck_int_re [*3]) // R4
    else $error("internal clock faster than divider allows");
  AST_RX_SHIFT: assert property (sck_stat.sck_ext_re |=> rx_shift[0] == $past(rx_in)) // R8 R9
    else $error("receive shifter took wrong sample");
  AST_RX_COUNT: assert property (sck_stat.sck_ext_re && state != ST_IDLE && !rx_load |=>
                                 rx_bits == $past(rx_bits) + 3'h1) // R11
    else $error("receive bit counter did not advance");

  COV_BYTE_DONE: cover property (state == ST_XFER ##1 state == ST_DONE);
  COV_BACK_TO_BACK: cover property (state == ST_CHK_START ##1 state == ST_UNMASK);
  COV_RX_FALL: cover property (rx_load && !control_register.miso_sample_edge_select);
  COV_CONFLICT: cover property (state == ST_XFER ##1 conflict);

endmodule
`default_nettype wire

// ---- tb/spi_slave_model.sv ----
// Behavioural SPI slave for mode 0, answering on slave select 0
`timescale 1ns/10ps
`default_nettype none
module spi_slave_model (
  input  wire logic       clk,     // System clock, paces idle pattern
  input  wire logic       sck,     // Serial clock from the bus
  input  wire logic       sel_n,   // Slave select, low selects
  input  wire logic       mosi,    // Data from master
  input  wire logic [7:0] tx_byte, // Byte to send back
  output logic            miso,    // Data to master
  output logic      [7:0] rx_byte  // Byte seen on mosi
);
  logic [7:0] sh;
  logic       idle_pat;
  initial begin
    sh = 8'h00;
    rx_byte = 8'h00;
    idle_pat = 1'b0;
  end
  // Deselected slave does not hold the line; a toggling level exposes stale sampling
  always @(posedge clk) idle_pat <= ~idle_pat;
  always @(negedge sel_n) sh = tx_byte;
  // Mode 0: drive on falling edge, MSB first
  always @(negedge sck) if (!sel_n) sh = {sh[6:0], 1'b0};
  always @(posedge sck) if (!sel_n) rx_byte = {rx_byte[6:0], mosi};
  assign miso = sel_n ? idle_pat : sh[7];
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the SPI master datapath
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module testbench;
  import spi_master_pkg::*;
  logic       clk, sys_rst, wr, rd, miso, master_select_n;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, ss_n, rx_seen, d;
  logic       irq, mosi, mosi_oe_n, sck, sck_oe_n, ss_oe_n;
  logic       sck_w, sel_w, mosi_w;
  int         mismatches, compares, n1, n2;
  // Released lines: clock and select have pull levels, data toggles
  assign sck_w  = sck_oe_n ? 1'b0 : sck;
  assign sel_w  = ss_oe_n ? 1'b1 : ss_n[0];
  assign mosi_w = mosi_oe_n ? ~clk : mosi;
  spi_master_datapath i_spi_master_datapath (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .mosi(mosi), .mosi_oe_n(mosi_oe_n), .miso(miso),
    .sck(sck), .sck_oe_n(sck_oe_n), .ss_n(ss_n), .ss_oe_n(ss_oe_n),
    .master_select_n(master_select_n));
  spi_slave_model i_spi_slave_model (
    .clk(clk), .sck(sck_w), .sel_n(sel_w), .mosi(mosi_w), .tx_byte(8'h3c),
    .miso(miso), .rx_byte(rx_seen));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_sck(input logic lvl, output int n);
    n = 0;
    while (sck_w !== lvl && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic wait_stat(input int b);
    int k;
    k = 0;
    d = 8'h00;
    while (d[b] !== 1'b1 && k < 200) begin
      rd_reg(OFF_STATUS, d);
      k++;
    end
  endtask
  task automatic t_reset;
    rd_reg(OFF_STATUS, d);
    `CHK(d, 8'h00)
    rd_reg(3'h7, d);
    `CHK(d, 8'h00)
    `CHK(irq, 1'b0)
    `CHK(ss_n, 8'hff)
    $display("t_reset done");
  endtask
  task automatic t_xfer;
    wr_reg(OFF_IRQ_MASK, 8'h07);
    wr_reg(OFF_TX_HOLD, 8'ha5);
    rd_reg(OFF_STATUS, d);
    `CHK(d[STAT_TX_EMPTY], 1'b0)
    wr_reg(OFF_SLAVE_SEL, 8'h01);
    wr_reg(OFF_CONTROL, 8'h53);
    wait_stat(STAT_TX_EMPTY);
    `CHK(d[STAT_TX_EMPTY], 1'b1)
    `CHK(ss_n, 8'hfe)
    wait_sck(1'b1, n1);
    wait_sck(1'b0, n1);
    wait_sck(1'b1, n1);
    wait_sck(1'b0, n2);
    `CHK(n1 + n2, 8)
    wait_stat(STAT_RX_FULL);
    `CHK(d[STAT_RX_FULL], 1'b1)
    `CHK(irq, 1'b1)
    rd_reg(OFF_RX_HOLD, d);
    `CHK(d, 8'h3c)
    rd_reg(OFF_STATUS, d);
    `CHK(d[STAT_RX_FULL], 1'b0)
    repeat (150) @(posedge clk);
    `CHK(rx_seen, 8'ha5)
    `CHK(sck, 1'b0)
    `CHK(ss_n, 8'hff)
    rd_reg(OFF_IRQ_STATUS, d);
    `CHK(d, 8'h03)
    `CHK(irq, 1'b0)
    // Start still set but holding register empty: no new frame
    repeat (60) @(posedge clk);
    `CHK(ss_n, 8'hff)
    wr_reg(OFF_CONTROL, 8'h00);
    $display("t_xfer done");
  endtask
  task automatic t_conflict;
    wr_reg(OFF_IRQ_MASK, 8'h04);
    wr_reg(OFF_CONTROL, 8'h01);
    @(posedge clk);
    master_select_n <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK({mosi_oe_n, sck_oe_n, ss_oe_n}, 3'h7)
    `CHK(irq, 1'b1)
    rd_reg(OFF_STATUS, d);
    `CHK(d[STAT_ERROR], 1'b1)
    @(posedge clk);
    master_select_n <= 1'b1;
    wr_reg(OFF_IRQ_MASK, 8'h00);
    `CHK(irq, 1'b0)
    rd_reg(OFF_IRQ_STATUS, d);
    `CHK(d, 8'h04)
    rd_reg(OFF_IRQ_STATUS, d);
    `CHK(d, 8'h00)
    wr_reg(OFF_STATUS, 8'h08);
    rd_reg(OFF_STATUS, d);
    `CHK(d[STAT_ERROR], 1'b0)
    `CHK({mosi_oe_n, sck_oe_n, ss_oe_n}, 3'h0)
    $display("t_conflict done");
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    test_done();
  end
  initial begin
    mismatches = 0;
    compares = 0;
    sys_rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    master_select_n = 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_xfer();
    t_conflict();
    test_done();
  end
endmodule
`default_nettype wire
